// ===== common/cfir_pkg.sv
package cfir_pkg;
    // Sample, coefficient and accumulator widths.
    localparam int SW     = 18;
    localparam int ACC_W  = 42;
    localparam int WORDS  = 32;
    // Paged register interface.
    localparam logic [5:0]  PAGE_ADDR  = 6'h21;
    localparam logic [5:0]  MODE_ADDR  = 6'h00;
    localparam logic [5:0]  GAIN_ADDR  = 6'h01;
    localparam logic [15:0] PAGE_LSB0  = 16'h0480;
    localparam logic [15:0] PAGE_LSB1  = 16'h04A0;
    localparam logic [15:0] PAGE_MSB0  = 16'h04C0;
    localparam logic [15:0] PAGE_MSB1  = 16'h04E0;
    localparam logic [15:0] PAGE_CTRL  = 16'h0500;
    localparam logic [15:0] PAGE_RST   = 16'h0000;
    localparam logic [15:0] MODE_RST   = 16'h0000;
    localparam logic [15:0] GAIN_RST   = 16'h0000;
    // Fields of the filter mode register and the gain register.
    localparam int TAPS_LSB   = 0;
    localparam int RAM_RD_BIT = 14;
    localparam int DUAL_BIT   = 15;
    localparam int GAIN_BIT   = 0;
    localparam int SHIFT_LO   = 19;
    localparam int SHIFT_HI   = 18;
    // Controller registers on the AXI4-Lite side.
    localparam logic [4:0] OFF_ADDR   = 5'h00;
    localparam logic [4:0] OFF_WDATA  = 5'h04;
    localparam logic [4:0] OFF_READ   = 5'h08;
    localparam logic [4:0] OFF_STATUS = 5'h0C;
    localparam logic [4:0] OFF_LIMIT  = 5'h10;
    localparam logic [4:0] OFF_COEF   = 5'h14;
    localparam int LIM_CDMA_BIT = 16;
endpackage : cfir_pkg

// ===== common/cfir_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// Paged 16-bit control bus between the host controller and the filter.
interface cfir_bus_if;
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        rack;
    modport device (input addr, wdata, wr, rd, output rdata, rack);
    modport host   (output addr, wdata, wr, rd, input rdata, rack);
endinterface : cfir_bus_if
`default_nettype wire

// ===== logic/cfir_device.sv
`timescale 1ns/1ps
`default_nettype none
module cfir_device (
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    cfir_bus_if.device                         bus,
    input  wire logic signed [cfir_pkg::SW-1:0] in_a,
    input  wire logic signed [cfir_pkg::SW-1:0] in_b,
    input  wire logic                          in_valid,
    output logic signed [cfir_pkg::SW-1:0]     out_a,
    output logic signed [cfir_pkg::SW-1:0]     out_b,
    output logic                               out_valid
);
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_MAC   = 2'b01,
        ST_ROUND = 2'b11
    } state_e;

    logic [15:0]                  page;
    logic [15:0]                  mode;
    logic [15:0]                  gain;
    logic [cfir_pkg::SW-1:0]      coef0 [cfir_pkg::WORDS];
    logic [cfir_pkg::SW-1:0]      coef1 [cfir_pkg::WORDS];
    logic [cfir_pkg::SW-1:0]      data_a [2*cfir_pkg::WORDS];
    logic [cfir_pkg::SW-1:0]      data_b [2*cfir_pkg::WORDS];
    state_e                       state;
    logic [5:0]                   wp;
    logic [5:0]                   base;
    logic [5:0]                   j;
    logic                         phase;
    logic signed [cfir_pkg::ACC_W-1:0] acc_a;
    logic signed [cfir_pkg::ACC_W-1:0] acc_b;
    logic [5:0]                   half;
    logic                         run;
    logic                         take;
    logic [5:0]                   a0;
    logic [5:0]                   a1;
    logic signed [cfir_pkg::ACC_W-1:0] next_acc_a;
    logic signed [cfir_pkg::ACC_W-1:0] next_acc_b;
    logic [2:0]                   sel;

    // Decodes a page into {hit, msb half, second RAM}.
    function automatic logic [2:0] ram_sel(input logic [15:0] p);
        case (p)
            cfir_pkg::PAGE_LSB0: ram_sel = 3'h4;
            cfir_pkg::PAGE_LSB1: ram_sel = 3'h5;
            cfir_pkg::PAGE_MSB0: ram_sel = 3'h6;
            cfir_pkg::PAGE_MSB1: ram_sel = 3'h7;
            default:             ram_sel = 3'h0;
        endcase
    endfunction : ram_sel

    // Saturates a scaled sum to the output width so it never wraps.
    function automatic logic [cfir_pkg::SW-1:0] sat(
        input logic signed [cfir_pkg::ACC_W-1:0] v);
        if (v > $signed(42'h1FFFF)) begin
            sat = 18'h1FFFF;
        end else if (v < -$signed(42'h20000)) begin
            sat = 18'h20000;
        end else begin
            sat = v[cfir_pkg::SW-1:0];
        end
    endfunction : sat

    // Field value zero stands for 32 words per section, i.e. 64 taps.
    assign half = (mode[cfir_pkg::TAPS_LSB +: 5] == 5'h00) ? 6'h20
                : {1'b0, mode[cfir_pkg::TAPS_LSB +: 5]};
    assign run  = !mode[cfir_pkg::RAM_RD_BIT];
    assign take = in_valid && run;
    assign sel  = ram_sel(page);

    // Page, mode and gain registers of the paged port.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page <= cfir_pkg::PAGE_RST;
            mode <= cfir_pkg::MODE_RST;
            gain <= cfir_pkg::GAIN_RST;
        end else if (bus.wr) begin
            if (bus.addr == cfir_pkg::PAGE_ADDR) begin
                page <= bus.wdata;
            end else if (page == cfir_pkg::PAGE_CTRL) begin
                if (bus.addr == cfir_pkg::MODE_ADDR) begin
                    mode <= bus.wdata;
                end else if (bus.addr == cfir_pkg::GAIN_ADDR) begin
                    gain <= bus.wdata;
                end
            end
        end
    end

    // Coefficient RAM writes; each half of a word keeps the other half.
    always_ff @(posedge aclk) begin
        if (bus.wr && bus.addr != cfir_pkg::PAGE_ADDR
            && bus.addr[5] == 1'b0 && sel[2]) begin
            if (sel[0]) begin
                if (sel[1]) begin
                    coef1[bus.addr[4:0]][17:2] <= bus.wdata;
                end else begin
                    coef1[bus.addr[4:0]][1:0] <= bus.wdata[1:0];
                end
            end else begin
                if (sel[1]) begin
                    coef0[bus.addr[4:0]][17:2] <= bus.wdata;
                end else begin
                    coef0[bus.addr[4:0]][1:0] <= bus.wdata[1:0];
                end
            end
        end
    end

    // Reads answer one cycle later; RAMs read as zero unless readback is on.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus.rdata <= 16'h0000;
            bus.rack  <= 1'b0;
        end else begin
            bus.rack  <= bus.rd;
            bus.rdata <= 16'h0000;
            if (bus.rd) begin
                if (bus.addr == cfir_pkg::PAGE_ADDR) begin
                    bus.rdata <= page;
                end else if (page == cfir_pkg::PAGE_CTRL) begin
                    if (bus.addr == cfir_pkg::MODE_ADDR) begin
                        bus.rdata <= mode;
                    end else if (bus.addr == cfir_pkg::GAIN_ADDR) begin
                        bus.rdata <= gain;
                    end
                end else if (!run && sel[2]
                             && bus.addr[5] == 1'b0) begin
                    case (sel[1:0])
                        2'b00:   bus.rdata <= {14'h0000,
                                     coef0[bus.addr[4:0]][1:0]};
                        2'b01:   bus.rdata <= {14'h0000,
                                     coef1[bus.addr[4:0]][1:0]};
                        2'b10:   bus.rdata <= coef0[bus.addr[4:0]][17:2];
                        default: bus.rdata <= coef1[bus.addr[4:0]][17:2];
                    endcase
                end
            end
        end
    end

    // Data RAMs: the input history of both channels, one shared pointer.
    always_ff @(posedge aclk) begin
        if (take) begin
            data_a[wp] <= in_a;
            data_b[wp] <= in_b;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp    <= 6'h00;
            phase <= 1'b0;
        end else if (take) begin
            wp    <= wp + 6'h01;
            phase <= !phase;
        end
    end

    // Section 0 walks the newest half, section 1 the older half.
    assign a0 = base - j;
    assign a1 = base - half - j;
    assign next_acc_a = acc_a
        + 42'($signed(coef0[j[4:0]]) * $signed(data_a[a0]))
        + 42'($signed(coef1[j[4:0]]) * $signed(data_a[a1]));
    assign next_acc_b = acc_b
        + 42'($signed(coef0[j[4:0]]) * $signed(data_b[a0]))
        + 42'($signed(coef1[j[4:0]]) * $signed(data_b[a1]));

    // Control machine: only the programmed taps are stepped through, so the
    // MAC phase lasts one cycle per word; the multipliers are never gated off.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            base  <= 6'h00;
            j     <= 6'h00;
            acc_a <= '0;
            acc_b <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take && phase) begin
                        base  <= wp;
                        j     <= 6'h00;
                        acc_a <= '0;
                        acc_b <= '0;
                        state <= ST_MAC;
                    end
                end
                ST_MAC: begin
                    acc_a <= next_acc_a;
                    acc_b <= mode[cfir_pkg::DUAL_BIT] ? next_acc_b : '0;
                    j     <= j + 6'h01;
                    if (j == half - 6'h01) begin
                        state <= ST_ROUND;
                    end
                end
                ST_ROUND: state <= ST_IDLE;
                default:  state <= ST_IDLE;
            endcase
        end
    end

    // Scale at full width, round half up, then saturate.
    logic [5:0]                        sh;
    logic signed [cfir_pkg::ACC_W-1:0] half_lsb;
    assign sh = gain[cfir_pkg::GAIN_BIT] ? 6'(cfir_pkg::SHIFT_HI)
                                         : 6'(cfir_pkg::SHIFT_LO);
    assign half_lsb = 42'sd1 <<< (sh - 6'h01);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_a     <= '0;
            out_b     <= '0;
            out_valid <= 1'b0;
        end else begin
            out_valid <= (state == ST_ROUND);
            if (state == ST_ROUND) begin
                out_a <= sat((acc_a + half_lsb) >>> sh);
                out_b <= sat((acc_b + half_lsb) >>> sh);
            end
        end
    end
endmodule : cfir_device
`default_nettype wire

// ===== logic/cfir_host.sv
`timescale 1ns/1ps
`default_nettype none
// AXI4-Lite controller that drives the paged filter bus.
module cfir_host (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    cfir_bus_if.host         bus
);
    logic [4:0]  aw_addr;
    logic        aw_have;
    logic [31:0] w_data;
    logic        w_have;
    logic        w_ok;
    logic [5:0]  cmd_addr;
    logic [31:0] limit;
    logic [15:0] rd_val;
    logic        rd_wait;
    logic        refused;
    logic [17:0] cf;
    logic [5:0]  cf_word;
    logic        cf_ram;
    logic [2:0]  step;
    logic        do_wr;
    logic [5:0]  max_half;
    logic [5:0]  req_half;

    // Highest legal tap field for the mode in LIMIT.
    assign max_half = !limit[cfir_pkg::LIM_CDMA_BIT] ? limit[13:8]
                    : limit[0] ? limit[5:0] + 6'h01
                    : limit[5:0];
    assign req_half = (w_data[4:0] == 5'h00) ? 6'h20 : {1'b0, w_data[4:0]};
    assign do_wr = aw_have && w_have && !s_axi_bvalid && step == 3'h0
                   && !rd_wait;

    // Write channels are taken independently, then paired.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            aw_addr       <= 5'h00;
            w_data        <= 32'h0000_0000;
            w_ok          <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= !aw_have && !s_axi_awready;
            s_axi_wready  <= !w_have && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_ok   <= &s_axi_wstrb;
            end
            if (do_wr) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Controller registers and the bus sequencer; a coefficient becomes
    // four bus writes: LSB page, LSB word, MSB page, MSB word.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_addr  <= 6'h00;
            limit     <= 32'h0000_0000;
            cf        <= 18'h00000;
            cf_word   <= 6'h00;
            cf_ram    <= 1'b0;
            step      <= 3'h0;
            refused   <= 1'b0;
            rd_wait   <= 1'b0;
            rd_val    <= 16'h0000;
            bus.addr  <= 6'h00;
            bus.wdata <= 16'h0000;
            bus.wr    <= 1'b0;
            bus.rd    <= 1'b0;
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            if (bus.rack) begin
                rd_val  <= bus.rdata;
                rd_wait <= 1'b0;
            end
            if (do_wr && w_ok) begin
                case (aw_addr)
                    cfir_pkg::OFF_ADDR:  cmd_addr <= w_data[5:0];
                    cfir_pkg::OFF_LIMIT: limit    <= w_data;
                    cfir_pkg::OFF_WDATA: begin
                        // Tap counts above the mode's limit never go out.
                        if (cmd_addr == cfir_pkg::MODE_ADDR
                            && req_half > max_half) begin
                            refused <= 1'b1;
                        end else begin
                            refused   <= 1'b0;
                            bus.addr  <= cmd_addr;
                            bus.wdata <= w_data[15:0];
                            bus.wr    <= 1'b1;
                        end
                    end
                    cfir_pkg::OFF_READ: begin
                        bus.addr <= cmd_addr;
                        bus.rd   <= 1'b1;
                        rd_wait  <= 1'b1;
                    end
                    cfir_pkg::OFF_COEF: begin
                        cf      <= w_data[17:0];
                        cf_word <= {1'b0, w_data[22:18]};
                        cf_ram  <= w_data[24];
                        step    <= 3'h1;
                    end
                    default: ;
                endcase
            end
            if (step != 3'h0) begin
                bus.wr <= 1'b1;
                step   <= (step == 3'h4) ? 3'h0 : step + 3'h1;
                case (step)
                    3'h1: begin
                        bus.addr  <= cfir_pkg::PAGE_ADDR;
                        bus.wdata <= cf_ram ? cfir_pkg::PAGE_LSB1
                                            : cfir_pkg::PAGE_LSB0;
                    end
                    3'h2: begin
                        bus.addr  <= cf_word;
                        bus.wdata <= {14'h0000, cf[1:0]};
                    end
                    3'h3: begin
                        bus.addr  <= cfir_pkg::PAGE_ADDR;
                        bus.wdata <= cf_ram ? cfir_pkg::PAGE_MSB1
                                            : cfir_pkg::PAGE_MSB0;
                    end
                    default: begin
                        bus.addr  <= cf_word;
                        bus.wdata <= cf[17:2];
                    end
                endcase
            end
        end
    end

    // Read channel; status shows busy, refusal and the last read value.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                case (s_axi_araddr)
                    cfir_pkg::OFF_ADDR:   s_axi_rdata <= {26'h0, cmd_addr};
                    cfir_pkg::OFF_LIMIT:  s_axi_rdata <= limit;
                    cfir_pkg::OFF_STATUS: s_axi_rdata <=
                        {14'h0, refused, (rd_wait || step != 3'h0), rd_val};
                    default:              s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : cfir_host
`default_nettype wire

// ===== sim/cfir_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the paged bus between the controller and the filter.
module cfir_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [5:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        rack
);
    logic [15:0] page;
    logic [15:0] mode;
    logic        gain;
    logic        ctl;
    logic        ram_pg;
    // Shadows follow bus writes only, so refused host writes never land.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            page <= cfir_pkg::PAGE_RST;
            mode <= cfir_pkg::MODE_RST;
            gain <= 1'b0;
        end else if (wr && addr == cfir_pkg::PAGE_ADDR) begin
            page <= wdata;
        end else if (wr && ctl && addr == cfir_pkg::MODE_ADDR) begin
            mode <= wdata;
        end else if (wr && ctl && addr == cfir_pkg::GAIN_ADDR) begin
            gain <= wdata[cfir_pkg::GAIN_BIT];
        end
    end
    // The four RAM pages differ only in bits 6 and 5.
    assign ctl    = page == cfir_pkg::PAGE_CTRL;
    assign ram_pg = page[15:7] == 9'h009 && page[4:0] == 5'h00;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_read; rd ##1 rack; endsequence
    sequence s_mode_rd; rd && ctl && addr == cfir_pkg::MODE_ADDR; endsequence
    property p_rack_lat; rd |-> s_read; endproperty
    property p_rack_cause; rack |-> $past(rd); endproperty
    property p_rd_pulse; rd |=> !rd; endproperty
    property p_rack_pulse; rack |=> !rack; endproperty
    property p_excl; !(wr && rd); endproperty
    property p_hidden; rd && ram_pg && !addr[5] && !mode[14] |=>
        rdata == 16'h0000; endproperty
    property p_mode_rb; s_mode_rd |=> rdata == mode; endproperty
    property p_gain_rb; rd && ctl && addr == cfir_pkg::GAIN_ADDR |=>
        rdata[cfir_pkg::GAIN_BIT] == gain; endproperty
    a_rack_lat: assert property (p_rack_lat)
        else $error("read answer late");
    a_rack_cause: assert property (p_rack_cause)
        else $error("answer without read");
    a_rd_pulse: assert property (p_rd_pulse)
        else $error("read strobe too long");
    a_rack_pulse: assert property (p_rack_pulse)
        else $error("answer strobe too long");
    a_excl: assert property (p_excl)
        else $error("write and read together");
    a_hidden: assert property (p_hidden)
        else $error("RAM visible without readback");
    a_mode_rb: assert property (p_mode_rb)
        else $error("mode readback wrong");
    a_gain_rb: assert property (p_gain_rb)
        else $error("gain readback wrong");
endmodule : cfir_checker
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic               aclk = 1'b0;
    logic               aresetn = 1'b0;
    logic [4:0]         s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]         s_axi_wstrb = 4'hF;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic               s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic               s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic               s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic signed [17:0] in_a = 18'h0, in_b = 18'h0, out_a, out_b;
    logic               in_valid = 1'b0, out_valid;
    int                 mismatches = 0, check_count = 0, seed = 13;
    logic signed [17:0] r0 [32], r1 [32], xa [$], xb [$], ea [$], eb [$];
    logic               ev [$];
    cfir_bus_if bus ();
    cfir_host i_cfir_host (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus(bus));
    cfir_device i_cfir_device (.aclk, .aresetn, .bus(bus), .in_a, .in_b,
        .in_valid, .out_a, .out_b, .out_valid);
    cfir_checker i_cfir_checker (.aclk(aclk), .aresetn(aresetn),
        .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
        .rdata(bus.rdata), .rack(bus.rack));
    // Clock at 20 MHz.
    initial forever #25 aclk = ~aclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic test_done;
        if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // AXI writes hold each channel until its own ready is seen.
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [4:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask : axr
    task automatic bw(input logic [5:0] a, input logic [15:0] d);
        axw(cfir_pkg::OFF_ADDR, {26'h0, a});
        axw(cfir_pkg::OFF_WDATA, {16'h0, d});
    endtask : bw
    // Busy polling has no fixed bound; the watchdog catches a hang.
    task automatic br(input logic [5:0] a, output logic [15:0] d);
        logic [31:0] s;
        axw(cfir_pkg::OFF_ADDR, {26'h0, a});
        axw(cfir_pkg::OFF_READ, 32'h0);
        do axr(cfir_pkg::OFF_STATUS, s); while (s[16]);
        d = s[15:0];
    endtask : br
    task automatic md(input logic [15:0] v);
        bw(cfir_pkg::PAGE_ADDR, cfir_pkg::PAGE_CTRL);
        bw(cfir_pkg::MODE_ADDR, v);
    endtask : md
    // Model output: newest sample meets tap 0, add-half round, then clamp.
    function automatic logic signed [17:0] fir(input logic signed [17:0] q [$],
                                               input int h, input logic g);
        longint s = 0;
        int     n = q.size();
        for (int k = 0; k < 2 * h && k < n; k++)
            s += (k < h ? r0[k] : r1[k - h]) * q[n - 1 - k];
        s = (s + (longint'(1) << (g ? 17 : 18))) >>> (g ? 18 : 19);
        if (s > 131071) s = 131071;
        if (s < -131072) s = -131072;
        return s[17:0];
    endfunction : fir
    // Samples are spaced by the MAC time; halted samples expect nothing.
    task automatic snd(input int n, input int h, input logic d,
                       input logic g, input logic hl);
        logic signed [17:0] a, b;
        for (int i = 0; i < n; i++) begin
            a = $random(seed);
            b = $random(seed);
            @(posedge aclk);
            in_a     <= a;
            in_b     <= b;
            in_valid <= 1'b1;
            @(posedge aclk);
            in_valid <= 1'b0;
            if (!hl) xa.push_back(a);
            if (!hl) xb.push_back(b);
            if (!hl && i % 2) begin
                ev.push_back(xa.size() >= 2 * h);
                ea.push_back(fir(xa, h, g));
                eb.push_back(d ? fir(xb, h, g) : 18'h0);
            end
            repeat (h + 1) @(posedge aclk);
        end
    endtask : snd
    // Outputs are checked once the bench history covers every tap.
    always @(posedge aclk) if (aresetn && out_valid === 1'b1) begin
        if (ea.size() == 0) chk(32'h1, 32'h0);
        else if (ev.pop_front()) begin
            chk(out_a, ea.pop_front());
            chk(out_b, eb.pop_front());
        end else begin
            void'(ea.pop_front());
            void'(eb.pop_front());
        end
    end
    initial begin
        logic [15:0]        d;
        logic signed [17:0] c;
        logic [31:0]        s;
        int                 h;
        int                 lim [3] = '{32'h1000E, 32'h1000F, 32'h0A00};
        int                 tf [3] = '{14, 16, 10};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        bw(cfir_pkg::PAGE_ADDR, cfir_pkg::PAGE_CTRL);
        br(cfir_pkg::MODE_ADDR, d);
        chk(d, cfir_pkg::MODE_RST);
        br(cfir_pkg::GAIN_ADDR, d);
        chk(d, cfir_pkg::GAIN_RST);
        for (int i = 0; i < 6; i++) begin
            axw(cfir_pkg::OFF_LIMIT, lim[i / 2]);
            md(16'h0007);
            md(16'(tf[i / 2] + i % 2));
            br(cfir_pkg::MODE_ADDR, d);
            chk(d, i % 2 ? 7 : tf[i / 2]);
            axr(cfir_pkg::OFF_STATUS, s);
            chk(s[17], i % 2);
        end
        s_axi_wstrb <= 4'h3;
        axw(cfir_pkg::OFF_LIMIT, 32'h0);
        s_axi_wstrb <= 4'hF;
        axr(cfir_pkg::OFF_LIMIT, s);
        chk(s, 32'h0A00);
        axw(cfir_pkg::OFF_LIMIT, 32'h1001F);
        for (int w = 0; w < 32; w++) begin
            r0[w] = w ? $random(seed) : 18'sh1FFFF;
            r1[w] = w ? $random(seed) : 18'sh20000;
            axw(cfir_pkg::OFF_COEF, {7'h0, 2'b00, w[4:0], r0[w]});
            axw(cfir_pkg::OFF_COEF, {7'h0, 2'b10, w[4:0], r1[w]});
        end
        md(16'h4007);
        snd(4, 7, 1'b0, 1'b0, 1'b1);
        for (int w = 0; w < 64; w++) begin
            c = w < 32 ? r0[w] : r1[w - 32];
            bw(cfir_pkg::PAGE_ADDR, w < 32 ? cfir_pkg::PAGE_LSB0
                                           : cfir_pkg::PAGE_LSB1);
            br(6'(w % 32), d);
            chk(d, c[1:0]);
            bw(cfir_pkg::PAGE_ADDR, w < 32 ? cfir_pkg::PAGE_MSB0
                                           : cfir_pkg::PAGE_MSB1);
            br(6'(w % 32), d);
            chk(d, c[17:2]);
        end
        md(16'h0007);
        bw(cfir_pkg::PAGE_ADDR, cfir_pkg::PAGE_LSB0);
        br(6'h00, d);
        chk(d, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            h = k[1] ? 32 : 7;
            md({k[0] ^ k[1], 10'h0, 5'(h % 32)});
            bw(cfir_pkg::GAIN_ADDR, {15'h0, k[0]});
            xa.delete();
            xb.delete();
            snd(4 * h + 8, h, k[0] ^ k[1], k[0], 1'b0);
            repeat (h + 8) @(posedge aclk);
            chk(ea.size(), 32'h0);
        end
        test_done;
    end
    // Watchdog sized well above the whole sequence.
    initial begin
        repeat (80000) @(posedge aclk);
        mismatches++;
        test_done;
    end
endmodule : tb
`default_nettype wire
